// ===== core/loc_conn_mem.sv
`timescale 1ns/100ps
// Operation
// - 8192 sixteen-bit words, one per output slot
// - Low fourteen address bits pick the word
// - Two word layouts, chosen by source rate
// - Bit 15 picks backplane or local memory
// - Message mode ignores side and stream fields
// - Bit 14 selects connection or message mode
// - Message mode sends the word's low byte
// - Serial byte leaves most significant bit first
// - Bit 13 enables drive, else high impedance
// - Slow layout stream is bits 12 to 8
// - Slow layout channel is bits 7 to 0
// - Fast layout stream is bits 12 to 9
// - Fast layout channel bits 8-0, message low byte
// - Address bit 14 plus select field reach memory
module loc_conn_mem (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Processor parallel port, asynchronous to clk
   input wire logic cpu_sel,
   input wire logic cpu_wr,
   input wire logic [loc_pkg::ADDR_W-1:0] cpu_addr,
   input wire logic [loc_pkg::WORD_W-1:0] cpu_wdata,
   output logic [loc_pkg::WORD_W-1:0] cpu_rdata,
   output logic cpu_ack,
   // Configuration from control logic
   input wire logic [2:0] memory_select_field,
   input wire logic local_target_32,
   input wire logic output_drive_style_pin,
   // Output slot requests from frame timing
   input wire logic play_valid,
   input wire logic [loc_pkg::DM_ADDR_W-1:0] play_addr,
   input wire logic play_src32,
   output logic play_ready,
   // Data memory read port
   output logic dm_rd_valid,
   output logic dm_rd_local,
   output logic [loc_pkg::DM_ADDR_W-1:0] dm_rd_addr,
   input wire logic dm_rdata_valid,
   input wire logic [loc_pkg::BYTE_W-1:0] dm_rdata,
   // Serial output
   output logic local_serial_outputs,
   output logic pin_oe,
   output logic ext_buf_oe
);
   import loc_pkg::*;

   // ==========================================================
   // Pin synchronisers
   // Bus is sampled whole; the strobe only rises once it has settled
   loc_pins_t pins_in, sync1, sync2, next_sync1, next_sync2;
   logic sel_prev, next_sel_prev;

   always_comb begin
      pins_in = '{sel: cpu_sel, wr: cpu_wr, style: output_drive_style_pin,
                  addr: cpu_addr, wdata: cpu_wdata};
      next_sync1 = pins_in;
      next_sync2 = sync1;
      next_sel_prev = sync2.sel;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sync1 <= '0;
         sync2 <= '0;
         sel_prev <= 1'b0;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         sel_prev <= next_sel_prev;
      end
   end

   // ==========================================================
   // Processor access decode
   logic cpu_hit, cpu_wr_go, cpu_rd_go;
   logic [IDX_W-1:0] cpu_idx;

   always_comb begin
      // Rising strobe only, so a held strobe makes one access
      cpu_hit = sync2.sel && !sel_prev && sync2.addr[A_MEM_SEL] &&
                (memory_select_field == SEL_LOCAL_CONN);
      cpu_wr_go = cpu_hit && sync2.wr;
      cpu_rd_go = cpu_hit && !sync2.wr;
      cpu_idx = map_index(sync2.addr[DM_ADDR_W-1:0], local_target_32);
   end

   // ==========================================================
   // Connection word storage
   logic [WORD_W-1:0] mem [WORDS];
   logic [WORD_W-1:0] rd_word;
   logic [IDX_W-1:0] rd_idx;
   logic [IDX_W-1:0] play_idx;
   logic [DM_ADDR_W-1:0] slot_addr, next_slot_addr;
   logic slot_src32, next_slot_src32;

   // Processor read wins the single read port; playout waits one cycle
   always_comb begin
      play_idx = map_index(slot_addr, local_target_32);
      rd_idx = cpu_rd_go ? cpu_idx : play_idx;
   end

   // Write port
   always_ff @(posedge clk) begin
      if (cpu_wr_go) begin
         mem[cpu_idx] <= sync2.wdata;
      end
   end

   // Read port has no reset so it can sit in block memory
   always_ff @(posedge clk) begin
      rd_word <= mem[rd_idx];
   end

   // ==========================================================
   // Processor answer
   logic rd_pend, next_rd_pend;
   logic [WORD_W-1:0] next_cpu_rdata;
   logic next_cpu_ack;

   // Read data holds until the next read; only reset clears it
   always_comb begin
      next_rd_pend = cpu_rd_go;
      next_cpu_ack = cpu_wr_go || rd_pend;
      next_cpu_rdata = rd_pend ? rd_word : cpu_rdata;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_pend <= 1'b0;
         cpu_ack <= 1'b0;
         cpu_rdata <= WORD_RESET;
      end else begin
         rd_pend <= next_rd_pend;
         cpu_ack <= next_cpu_ack;
         cpu_rdata <= next_cpu_rdata;
      end
   end

   // ==========================================================
   // Slot lookup sequencer
   loc_state_t state, next_state;
   loc_word_t word_q;
   loc_slot_t slot, next_slot;
   logic look_ok;
   logic next_play_ready, next_dm_rd_valid, next_dm_rd_local;
   logic [DM_ADDR_W-1:0] next_dm_rd_addr;
   logic fifo_in_valid, next_fifo_in_valid, fifo_in_ready;

   // Data memory address in processor form, unused bit held at zero
   function automatic logic [DM_ADDR_W-1:0] dm_addr_of(input logic [WORD_W-1:0] w,
                                                       input logic src32);
      if (src32) begin
         dm_addr_of = {1'b0, w[W_STRM_HI:W_STRM4_LO], w[W_CHAN9_HI:0]};
      end else begin
         dm_addr_of = {w[W_STRM_HI:W_STRM5_LO], 1'b0, w[W_CHAN8_HI:0]};
      end
   endfunction

   always_comb begin
      word_q = loc_word_t'(rd_word);
      look_ok = !cpu_rd_go;
      next_state = state;
      next_slot = slot;
      next_slot_addr = slot_addr;
      next_slot_src32 = slot_src32;
      next_play_ready = play_ready;
      next_dm_rd_valid = 1'b0;
      next_dm_rd_local = dm_rd_local;
      next_dm_rd_addr = dm_rd_addr;
      next_fifo_in_valid = fifo_in_valid;
      unique case (state)
         ST_IDLE: begin
            if (play_valid && play_ready) begin
               next_slot_addr = play_addr;
               next_slot_src32 = play_src32;
               next_play_ready = 1'b0;
               next_state = ST_LOOK;
            end
         end
         ST_LOOK: begin
            // Stalls while a processor read holds the port
            if (look_ok) begin
               next_state = ST_DEC;
            end
         end
         ST_DEC: begin
            next_slot.enable = word_q.channel_output_enable;
            if (word_q.message_mode_select) begin
               // Side and stream fields play no part here
               next_slot.data = rd_word[W_CHAN8_HI:0];
               next_fifo_in_valid = 1'b1;
               next_state = ST_PUSH;
            end else begin
               next_dm_rd_valid = 1'b1;
               next_dm_rd_local = word_q.source_side_select;
               next_dm_rd_addr = dm_addr_of(rd_word, slot_src32);
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            // Any data memory latency is accepted
            if (dm_rdata_valid) begin
               next_slot.data = dm_rdata;
               next_fifo_in_valid = 1'b1;
               next_state = ST_PUSH;
            end
         end
         ST_PUSH: begin
            // Full buffer holds the sequencer and so the frame timing
            if (fifo_in_ready) begin
               next_fifo_in_valid = 1'b0;
               next_play_ready = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_play_ready = 1'b1;
            next_fifo_in_valid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         slot <= '0;
         slot_addr <= '0;
         slot_src32 <= 1'b0;
         play_ready <= 1'b1;
         dm_rd_valid <= 1'b0;
         dm_rd_local <= 1'b0;
         dm_rd_addr <= '0;
         fifo_in_valid <= 1'b0;
      end else begin
         state <= next_state;
         slot <= next_slot;
         slot_addr <= next_slot_addr;
         slot_src32 <= next_slot_src32;
         play_ready <= next_play_ready;
         dm_rd_valid <= next_dm_rd_valid;
         dm_rd_local <= next_dm_rd_local;
         dm_rd_addr <= next_dm_rd_addr;
         fifo_in_valid <= next_fifo_in_valid;
      end
   end

   // ==========================================================
   // Slot buffer
   logic fifo_out_valid, fifo_out_ready;
   logic [SLOT_W-1:0] fifo_out_data;
   loc_slot_t head;

   loc_fifo #(
      .WIDTH(SLOT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(slot),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // ==========================================================
   // Bit rate divider
   // Free-running; the shifter count alone marks slot edges
   logic [3:0] div_cnt, next_div_cnt;
   logic bit_tick;

   always_comb begin
      bit_tick = (div_cnt == 4'(BIT_DIV - 1));
      next_div_cnt = bit_tick ? 4'h0 : div_cnt + 4'h1;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         div_cnt <= 4'h0;
      end else begin
         div_cnt <= next_div_cnt;
      end
   end

   // ==========================================================
   // Serialiser
   logic [BYTE_W-1:0] sh_byte, next_sh_byte;
   logic [3:0] sh_cnt, next_sh_cnt;
   logic sh_en, next_sh_en;
   logic next_pin_oe, next_ext_buf_oe;

   always_comb begin
      head = loc_slot_t'(fifo_out_data);
      // Pop only on the tick that loads, never mid-byte
      fifo_out_ready = bit_tick && (sh_cnt <= 4'h1);
      next_sh_byte = sh_byte;
      next_sh_cnt = sh_cnt;
      next_sh_en = sh_en;
      if (bit_tick) begin
         if (sh_cnt > 4'h1) begin
            next_sh_byte = {sh_byte[BYTE_W-2:0], 1'b0};
            next_sh_cnt = sh_cnt - 4'h1;
         end else if (fifo_out_valid) begin
            next_sh_byte = head.data;
            next_sh_en = head.enable;
            next_sh_cnt = BITS_PER_SLOT;
         end else begin
            // Underrun leaves the line undriven
            next_sh_en = 1'b0;
            next_sh_cnt = 4'h0;
         end
      end
      // Style pin low: tristate here; high: steer an external buffer
      next_pin_oe = next_sh_en && !sync2.style;
      next_ext_buf_oe = next_sh_en && sync2.style;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sh_byte <= '0;
         sh_cnt <= 4'h0;
         sh_en <= 1'b0;
         pin_oe <= 1'b0;
         ext_buf_oe <= 1'b0;
      end else begin
         sh_byte <= next_sh_byte;
         sh_cnt <= next_sh_cnt;
         sh_en <= next_sh_en;
         pin_oe <= next_pin_oe;
         ext_buf_oe <= next_ext_buf_oe;
      end
   end

   assign local_serial_outputs = sh_byte[BYTE_W-1];

endmodule // loc_conn_mem

// ===== core/loc_fifo.sv
`timescale 1ns/100ps
module loc_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [PW:0] count, next_count;
   logic push, pop;

   // ==========================================================
   // Pointer control
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end

   assign in_ready = (count != DEPTH[PW:0]);
   assign out_valid = (count != '0);
   assign out_data = store[rd_ptr];

endmodule // loc_fifo

// ===== core/loc_pkg.sv
package loc_pkg;

   // ==========================================================
   // Memory geometry
   localparam int WORDS = 8192;
   localparam int IDX_W = 13;
   localparam int ADDR_W = 15;
   localparam int DM_ADDR_W = 14;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;

   // ==========================================================
   // Processor address fields
   localparam int A_MEM_SEL = 14;
   localparam int A_STRM_HI = 13;
   localparam int A_STRM_LO = 9;
   localparam int A_CHAN_HI = 8;
   localparam int A_CHAN32_LO = 0;
   localparam int A_CHAN_HI8 = 7;

   // Memory select code that reaches this memory
   localparam logic [2:0] SEL_LOCAL_CONN = 3'h0;

   // ==========================================================
   // Connection word layout
   localparam int W_SRC_SIDE = 15;
   localparam int W_MSG_MODE = 14;
   localparam int W_OUT_EN = 13;
   localparam int W_STRM_HI = 12;
   localparam int W_STRM5_LO = 8;
   localparam int W_STRM4_LO = 9;
   localparam int W_CHAN9_HI = 8;
   localparam int W_CHAN8_HI = 7;
   localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

   // ==========================================================
   // Serial timing
   localparam int CLK_NS = 20;
   localparam int BIT_NS = 80;
   localparam int BIT_DIV = (BIT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] BITS_PER_SLOT = 4'h8;
   localparam int FIFO_DEPTH = 16;

   typedef struct packed {
      logic source_side_select;
      logic message_mode_select;
      logic channel_output_enable;
      logic [12:0] source_field;
   } loc_word_t;

   typedef struct packed {
      logic enable;
      logic [BYTE_W-1:0] data;
   } loc_slot_t;

   localparam int SLOT_W = $bits(loc_slot_t);

   typedef struct packed {
      logic sel;
      logic wr;
      logic style;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
   } loc_pins_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LOOK = 3'b001,
      ST_DEC = 3'b010,
      ST_WAIT = 3'b011,
      ST_PUSH = 3'b100
   } loc_state_t;

   // Word index of a stream/channel pair for the given stream rate
   function automatic logic [IDX_W-1:0] map_index(input logic [DM_ADDR_W-1:0] a,
                                                  input logic is32);
      if (is32) begin
         map_index = {a[A_STRM_HI-1:A_STRM_LO], a[A_CHAN_HI:A_CHAN32_LO]};
      end else begin
         map_index = {a[A_STRM_HI:A_STRM_LO], a[A_CHAN_HI8:A_CHAN32_LO]};
      end
   endfunction

endpackage

// ===== test/loc_conn_mem_assertions.sv
`timescale 1ns/100ps
module loc_conn_mem_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Processor port
   input wire logic cpu_ack,
   input wire logic [loc_pkg::ADDR_W-1:0] cpu_addr,
   input wire logic [loc_pkg::WORD_W-1:0] cpu_rdata,
   input wire logic [2:0] memory_select_field,
   // Slot and data memory side
   input wire logic output_drive_style_pin,
   input wire logic play_valid,
   input wire logic play_ready,
   input wire logic dm_rd_valid,
   // Serial output
   input wire logic local_serial_outputs,
   input wire logic pin_oe,
   input wire logic ext_buf_oe
);
   import loc_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // ==========================================================
   // Serial bit timing
   sequence s_bit_held;
      $stable(local_serial_outputs) [*3];
   endsequence

   // ==========================================================
   // Checks
   a_ack_one_cycle: assert property (cpu_ack |=> !cpu_ack)
      else $error("ack longer than one cycle");
   a_ack_only_mapped: assert property (cpu_ack |-> cpu_addr[A_MEM_SEL]
      && memory_select_field == SEL_LOCAL_CONN) else $error("ack on unmapped access");
   a_rdata_with_ack: assert property ($changed(cpu_rdata) |-> cpu_ack)
      else $error("read data moved without ack");
   a_take_busy: assert property (play_valid && play_ready |=> !play_ready)
      else $error("ready stayed high after take");
   a_dm_rd_pulse: assert property (dm_rd_valid |=> !dm_rd_valid)
      else $error("data memory read longer than one cycle");
   a_dm_rd_busy: assert property (dm_rd_valid |-> !play_ready)
      else $error("data memory read while idle");
   a_pin_oe_style: assert property (pin_oe |-> !$past(output_drive_style_pin, 3))
      else $error("pin driven in external buffer style");
   a_buf_oe_style: assert property (ext_buf_oe |->
      $past(output_drive_style_pin, 3) && !pin_oe) else $error("buffer enable in pin style");
   a_bit_period: assert property ($changed(local_serial_outputs) |=> s_bit_held)
      else $error("serial bit shorter than four clocks");
endmodule // loc_conn_mem_assertions

bind loc_conn_mem loc_conn_mem_assertions u_chk (.clk, .rst_b, .cpu_ack, .cpu_addr,
   .cpu_rdata, .memory_select_field, .output_drive_style_pin, .play_valid, .play_ready,
   .dm_rd_valid, .local_serial_outputs, .pin_oe, .ext_buf_oe);

// ===== test/loc_dm_model.sv
`timescale 1ns/100ps
module loc_dm_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Read request
   input wire logic rd_valid,
   input wire logic rd_local,
   input wire logic [loc_pkg::DM_ADDR_W-1:0] rd_addr,
   input wire logic slow,
   // Read answer
   output logic rdata_valid,
   output logic [loc_pkg::BYTE_W-1:0] rdata
);
   import loc_pkg::*;
   logic [2:0] cnt;
   logic [BYTE_W-1:0] held;

   always_ff @(posedge clk) begin
      rdata_valid <= 1'b0;
      // Undriven bus toggles so a stale byte never passes
      rdata <= ~rdata;
      if (!rst_b) begin
         cnt <= 3'h0;
         rdata <= 8'h00;
      end else if (rd_valid) begin
         cnt <= slow ? 3'h5 : 3'h1;
         held <= rd_local ? ~rd_addr[7:0] : rd_addr[7:0] ^ 8'h5a;
      end else if (cnt != 3'h0) begin
         cnt <= cnt - 3'h1;
         if (cnt == 3'h1) begin
            rdata_valid <= 1'b1;
            rdata <= held;
         end
      end
   end
endmodule // loc_dm_model

// ===== test/tb.sv
`timescale 1ns/100ps
module tb;
   import loc_pkg::*;
   logic clk;
   logic rst_b;
   logic cpu_sel, cpu_wr, cpu_ack, output_drive_style_pin, slow, target32;
   logic [ADDR_W-1:0] cpu_addr;
   logic [WORD_W-1:0] cpu_wdata, cpu_rdata;
   logic [2:0] memory_select_field;
   logic play_valid, play_src32, play_ready, dm_rd_valid, dm_rd_local, dm_rdata_valid;
   logic local_serial_outputs, pin_oe, ext_buf_oe;
   logic [DM_ADDR_W-1:0] play_addr, dm_rd_addr;
   logic [BYTE_W-1:0] dm_rdata;
   int n_errors, samples_checked, cycles;

   loc_conn_mem u_dut (.clk, .rst_b, .cpu_sel, .cpu_wr, .cpu_addr, .cpu_wdata, .cpu_rdata,
      .cpu_ack, .memory_select_field, .local_target_32(target32), .output_drive_style_pin,
      .play_valid, .play_addr, .play_src32, .play_ready, .dm_rd_valid, .dm_rd_local,
      .dm_rd_addr, .dm_rdata_valid, .dm_rdata, .local_serial_outputs, .pin_oe, .ext_buf_oe);
   loc_dm_model u_dm (.clk, .rst_b, .rd_valid(dm_rd_valid), .rd_local(dm_rd_local),
      .rd_addr(dm_rd_addr), .slow, .rdata_valid(dm_rdata_valid), .rdata(dm_rdata));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Run ceiling well above the several hundred cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         give_verdict;
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cpu_access(input logic wr, input logic [14:0] a, input logic [15:0] wd,
         output logic [15:0] rd, output logic acked);
      @(posedge clk);
      cpu_wr <= wr;
      cpu_addr <= a;
      cpu_wdata <= wd;
      repeat (3) @(posedge clk);
      cpu_sel <= 1'b1;
      acked = 1'b0;
      rd = 16'h0000;
      for (int i = 0; i < 12; i++) begin
         @(negedge clk);
         if (cpu_ack === 1'b1) begin
            acked = 1'b1;
            rd = cpu_rdata;
         end
      end
      @(posedge clk);
      cpu_sel <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic run_slot(input logic [13:0] a, input logic [15:0] w, input logic s32,
         input logic st, input logic exp_rd, input logic [13:0] exp_addr, input logic [7:0] eb);
      logic [15:0] rd;
      logic ok, seen_rd, on;
      logic [7:0] b;
      output_drive_style_pin <= st;
      cpu_access(1'b1, {1'b1, a}, w, rd, ok);
      seen_rd = 1'b0;
      on = 1'b0;
      b = 8'h00;
      @(posedge clk);
      play_valid <= 1'b1;
      play_addr <= a;
      play_src32 <= s32;
      @(posedge clk);
      play_valid <= 1'b0;
      for (int i = 0; i < 80 && !on; i++) begin
         @(negedge clk);
         if (dm_rd_valid === 1'b1) begin
            seen_rd = 1'b1;
            check("dm_rd_addr", 16'(dm_rd_addr), 16'(exp_addr));
            check("dm_rd_local", 16'(dm_rd_local), 16'(w[15]));
         end
         on = pin_oe | ext_buf_oe;
      end
      check("dm read", 16'(seen_rd), 16'(exp_rd));
      check("pin_oe", 16'(pin_oe), 16'(w[13] & !st));
      check("ext_buf_oe", 16'(ext_buf_oe), 16'(w[13] & st));
      for (int k = 7; k >= 0; k--) begin
         b[k] = local_serial_outputs;
         repeat (4) @(negedge clk);
      end
      if (w[13]) check("serial byte", 16'(b), 16'(eb));
      repeat (12) @(posedge clk);
   endtask

   // ==========================================================
   // Scenarios
   task automatic test_regs;
      logic [15:0] rd;
      logic ok;
      check("cpu_rdata reset", cpu_rdata, 16'h0000);
      check("play_ready reset", 16'(play_ready), 16'h0001);
      cpu_access(1'b1, 15'h7fff, 16'hbeef, rd, ok);
      cpu_access(1'b0, 15'h7fff, 16'h0000, rd, ok);
      check("readback", rd, 16'hbeef);
      cpu_access(1'b1, 15'h3fff, 16'h1234, rd, ok);
      check("register space ack", 16'(ok), 16'h0000);
      memory_select_field <= 3'h1;
      cpu_access(1'b1, 15'h7fff, 16'h4321, rd, ok);
      check("other memory ack", 16'(ok), 16'h0000);
      memory_select_field <= 3'h0;
      cpu_access(1'b0, 15'h7fff, 16'h0000, rd, ok);
      check("no overwrite", rd, 16'hbeef);
   endtask

   task automatic test_target32;
      logic [15:0] rd;
      logic ok;
      target32 <= 1'b1;
      cpu_access(1'b1, 15'h4100, 16'h1111, rd, ok);
      cpu_access(1'b1, 15'h4000, 16'h2222, rd, ok);
      cpu_access(1'b0, 15'h4100, 16'h0000, rd, ok);
      check("fast map channel 256", rd, 16'h1111);
      cpu_access(1'b0, 15'h4000, 16'h0000, rd, ok);
      check("fast map channel 0", rd, 16'h2222);
      target32 <= 1'b0;
   endtask

   task automatic test_message;
      run_slot(14'h0201, 16'hffc3, 1'b0, 1'b0, 1'b0, 14'h0000, 8'hc3);
      run_slot(14'h0402, 16'h7f96, 1'b1, 1'b1, 1'b0, 14'h0000, 8'h96);
   endtask

   task automatic test_conn_slow;
      run_slot(14'h0603, 16'ha5a5, 1'b0, 1'b0, 1'b1, 14'h0aa5, 8'h5a);
   endtask

   task automatic test_conn_fast;
      slow <= 1'b1;
      run_slot(14'h0804, 16'h233c, 1'b1, 1'b1, 1'b1, 14'h033c, 8'h66);
      slow <= 1'b0;
   endtask

   task automatic test_disabled;
      run_slot(14'h0a05, 16'hc077, 1'b0, 1'b0, 1'b0, 14'h0000, 8'h77);
   endtask

   task automatic give_verdict;
      if (n_errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      rst_b = 1'b0;
      cpu_sel = 1'b0;
      cpu_wr = 1'b0;
      cpu_addr = 15'h0000;
      cpu_wdata = 16'h0000;
      memory_select_field = 3'h0;
      output_drive_style_pin = 1'b0;
      slow = 1'b0;
      target32 = 1'b0;
      play_valid = 1'b0;
      play_addr = 14'h0000;
      play_src32 = 1'b0;
      n_errors = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      test_regs;
      test_target32;
      test_message;
      test_conn_slow;
      test_conn_fast;
      test_disabled;
      give_verdict;
   end
endmodule // tb
